// File: rtl/pgfti_pkg.sv
// Package with register map, field positions and reset values of the power-good and top interrupt block
package pgfti_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PGFTI_ADDR_PG_CTRL_ONE = 8'h15;
    localparam logic [7:0] PGFTI_ADDR_PG_CTRL_TWO = 8'h16;
    localparam logic [7:0] PGFTI_ADDR_FAULT_LATCH = 8'h17;
    localparam logic [7:0] PGFTI_ADDR_SOFT_RESET = 8'h18;
    localparam logic [7:0] PGFTI_ADDR_TOP_IRQ = 8'h19;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PGFTI_RST_PG_CTRL_ONE = 8'h7F;
    localparam logic [2:0] PGFTI_RST_PG_CTRL_TWO = 3'h4;
    localparam logic [3:0] PGFTI_RST_FAULT_LATCH = 4'h0;
    localparam logic [7:0] PGFTI_RST_TOP_IRQ = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // Control one: bits 3:0 per-regulator monitor enables, bit 7 polarity
    localparam int PGFTI_POS_PG_POLARITY = 7;
    // Control two
    localparam int PGFTI_POS_TWARN_MON_EN = 2;
    localparam int PGFTI_POS_FAULT_GATING = 1;
    localparam int PGFTI_POS_PG_OPER_SEL = 0;
    // Soft reset command
    localparam int PGFTI_POS_SOFT_RESET_CMD = 0;
    // Top interrupt status
    localparam int PGFTI_POS_PG_DROP_IRQ = 7;
    localparam int PGFTI_POS_LINEAR_SUM_IRQ = 6;
    localparam int PGFTI_POS_STEPDOWN_SUM_IRQ = 5;
    localparam int PGFTI_POS_SYNC_CLK_IRQ = 4;
    localparam int PGFTI_POS_THERM_SD_IRQ = 3;
    localparam int PGFTI_POS_THERM_WARN_IRQ = 2;
    localparam int PGFTI_POS_OVERVOLT_IRQ = 1;
    localparam int PGFTI_POS_CURRENT_RES_IRQ = 0;

    // Number of regulators, the width of all 4-bit per-regulator vectors
    localparam int PGFTI_NUM_REG = 4;

endpackage

// File: rtl/pgfti_sticky_bank.sv
// Bank of sticky flags with synchronous set and clear, set winning over clear
`timescale 1ns/1ps
`default_nettype none

module pgfti_sticky_bank #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic flush,
    input wire logic [WIDTH-1:0] set_vec,
    input wire logic [WIDTH-1:0] clr_vec,
    output logic [WIDTH-1:0] flag
);

    // ------------------------------------------------------------
    // Per-bit flag
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            // Set beats clear, flush beats both
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    flag[i] <= 1'b0;
                end else if (flush) begin
                    flag[i] <= 1'b0;
                end else if (set_vec[i]) begin
                    flag[i] <= 1'b1;
                end else if (clr_vec[i]) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // pgfti_sticky_bank

`default_nettype wire

// File: rtl/pgfti_top.sv
// Power-good control, fault latches, soft reset command and top interrupt status
// Functional notes
// (RL1) Thermal warning forces power-good inactive only when its monitor enable is set.
// (RL2) Gating select 0 uses live outputs; 1 uses fault latches, inactive if any set.
// (RL3) One-bit power-good operating mode: 0 gated, 1 continuous.
// (RL4) Four fault latches, bits 3..0, set when monitored regulator drops power-good.
// (RL5) Fault latch clears on write-one only while its regulator output is valid.
// (RL6) Writing one to soft reset bit restores defaults, reloads OTP, resets serial interface.
// (RL7) Soft reset bit clears itself after the reset action.
// (RL8) Power-good drop interrupt, bit 7, latches on active-to-inactive pin change.
// (RL9) Linear summary bit reads one while the linear interrupt register is nonzero.
// (RL10) Step-down summary bit reads one while the step-down interrupt register is nonzero.
// (RL11) Clock-sync interrupt, bit 4, latches on external clock appearing or disappearing.
// (RL12) Thermal shutdown latches bit 3, disables regulators, drives both outputs low.
// (RL13) While thermal shutdown bit is set, no regulator may be enabled.
// (RL14) Thermal warning interrupt, bit 2, latches when warning level is exceeded.
// (RL15) Overvoltage latches bit 1, disables regulators, drives both outputs low.
// (RL16) Current result interrupt, bit 0, latches when a new measurement is stored.
// (RL17) Latched top interrupt bits clear on write-one; write-zero leaves them.
// (RL18) Per-regulator power-good source enable includes or excludes it from monitoring.
// (RL19) Interrupt output is high while any unmasked top interrupt bit is set.
`timescale 1ns/1ps
`default_nettype none

module pgfti_top
    import pgfti_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    // Decoded register access from the serial control front end
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Analog monitor results, index 0 step-down a, 1 step-down b, 2 linear a, 3 linear b
    input wire logic [3:0] regulator_valid,
    input wire logic thermal_warn,
    input wire logic thermal_shutdown,
    input wire logic input_overvolt,
    input wire logic sync_clk_present,
    input wire logic current_result_stored,
    input wire logic [7:0] stepdown_irq_register,
    input wire logic [7:0] linear_irq_register,
    input wire logic [7:0] top_irq_mask,
    // Regulator and general output requests from the sequencer
    input wire logic [3:0] regulator_en_req,
    input wire logic general_output_a_req,
    input wire logic general_output_b_req,
    // Outputs
    output logic [3:0] regulator_en,
    output logic general_output_a,
    output logic general_output_b,
    output logic power_good_out,
    output logic irq_out,
    output logic otp_reload,
    output logic serial_if_reset
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] pg_ctrl_one;
    logic [2:0] pg_ctrl_two;
    logic [3:0] fault_latch;
    logic [7:0] top_irq;
    logic soft_reset_pulse;
    logic wr_fault;
    logic wr_top;
    logic wr_soft;
    logic [3:0] monitor_en;
    logic thermal_warn_monitor_en;
    logic fault_gating_select;
    logic power_good_operating_sel;
    logic warn_block;
    logic live_good;
    logic latch_good;
    logic pg_active;
    logic pg_active_q;
    logic [3:0] fault_set;
    logic [3:0] fault_clr;
    logic [7:0] irq_set;
    logic [7:0] irq_clr;
    logic linear_summary_irq;
    logic stepdown_summary_irq;
    logic sync_clk_q;
    logic therm_sd_q;
    logic therm_warn_q;
    logic overvolt_q;
    logic protect_event;
    logic [3:0] en_req_q;
    logic gen_out_a_req_q;
    logic gen_out_b_req_q;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    assign wr_fault = reg_wr && (reg_addr == PGFTI_ADDR_FAULT_LATCH);
    assign wr_top = reg_wr && (reg_addr == PGFTI_ADDR_TOP_IRQ);
    assign wr_soft = reg_wr && (reg_addr == PGFTI_ADDR_SOFT_RESET) && reg_wdata[PGFTI_POS_SOFT_RESET_CMD];

    // Soft reset strobe, one cycle, never readable as one
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= wr_soft; // RL6 RL7
        end
    end

    // OTP reload and serial interface reset requests
    assign otp_reload = soft_reset_pulse; // RL6
    assign serial_if_reset = soft_reset_pulse; // RL6

    // ------------------------------------------------------------
    // Power-good control registers
    // ------------------------------------------------------------
    // Control one: source enables and polarity
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pg_ctrl_one <= PGFTI_RST_PG_CTRL_ONE;
        end else if (soft_reset_pulse) begin
            pg_ctrl_one <= PGFTI_RST_PG_CTRL_ONE; // RL6
        end else if (reg_wr && (reg_addr == PGFTI_ADDR_PG_CTRL_ONE)) begin
            pg_ctrl_one <= reg_wdata;
        end
    end

    // Control two: warning monitor, gating select, operating mode
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pg_ctrl_two <= PGFTI_RST_PG_CTRL_TWO;
        end else if (soft_reset_pulse) begin
            pg_ctrl_two <= PGFTI_RST_PG_CTRL_TWO; // RL6
        end else if (reg_wr && (reg_addr == PGFTI_ADDR_PG_CTRL_TWO)) begin
            pg_ctrl_two <= reg_wdata[2:0]; // RL3
        end
    end

    assign monitor_en = pg_ctrl_one[3:0]; // RL18
    assign thermal_warn_monitor_en = pg_ctrl_two[PGFTI_POS_TWARN_MON_EN];
    assign fault_gating_select = pg_ctrl_two[PGFTI_POS_FAULT_GATING];
    assign power_good_operating_sel = pg_ctrl_two[PGFTI_POS_PG_OPER_SEL];

    // ------------------------------------------------------------
    // Power-good evaluation
    // ------------------------------------------------------------
    // Warning only matters when its monitor enable is set
    assign warn_block = thermal_warn_monitor_en && thermal_warn; // RL1
    // Live result: excluded regulators count as good; gated mode also needs them enabled
    assign live_good = &(regulator_valid | ~monitor_en) && // RL18
        (power_good_operating_sel || &(regulator_en | ~monitor_en)); // RL3
    // Latched result: any fault latch holds power-good inactive
    assign latch_good = (fault_latch == 4'h0); // RL2
    assign pg_active = !warn_block && (fault_gating_select ? latch_good : live_good); // RL1 RL2

    // Registered pin level with polarity
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pg_active_q <= 1'b0;
            power_good_out <= 1'b0;
        end else begin
            pg_active_q <= pg_active;
            power_good_out <= pg_active ^ pg_ctrl_one[PGFTI_POS_PG_POLARITY];
        end
    end

    // ------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------
    // Monitored regulator that is not valid drops power-good and latches
    assign fault_set = monitor_en & ~regulator_valid; // RL4
    // Write-one clears only while the output is valid
    assign fault_clr = wr_fault ? (reg_wdata[3:0] & regulator_valid) : 4'h0; // RL5

    pgfti_sticky_bank #(
        .WIDTH(PGFTI_NUM_REG)
    ) u_fault_bank (
        .mclk(mclk),
        .rstn(rstn),
        .flush(soft_reset_pulse),
        .set_vec(fault_set),
        .clr_vec(fault_clr),
        .flag(fault_latch)
    );

    // ------------------------------------------------------------
    // Event edge detection
    // ------------------------------------------------------------
    // Previous values of the live monitor levels
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync_clk_q <= 1'b0;
            therm_sd_q <= 1'b0;
            therm_warn_q <= 1'b0;
            overvolt_q <= 1'b0;
        end else begin
            sync_clk_q <= sync_clk_present;
            therm_sd_q <= thermal_shutdown;
            therm_warn_q <= thermal_warn;
            overvolt_q <= input_overvolt;
        end
    end

    // ------------------------------------------------------------
    // Top interrupt status
    // ------------------------------------------------------------
    // Event sources into the sticky bits
    always_comb begin
        irq_set = 8'h00;
        irq_set[PGFTI_POS_PG_DROP_IRQ] = pg_active_q && !pg_active; // RL8
        irq_set[PGFTI_POS_SYNC_CLK_IRQ] = sync_clk_q ^ sync_clk_present; // RL11
        irq_set[PGFTI_POS_THERM_SD_IRQ] = thermal_shutdown && !therm_sd_q; // RL12
        irq_set[PGFTI_POS_THERM_WARN_IRQ] = thermal_warn && !therm_warn_q; // RL14
        irq_set[PGFTI_POS_OVERVOLT_IRQ] = input_overvolt && !overvolt_q; // RL15
        irq_set[PGFTI_POS_CURRENT_RES_IRQ] = current_result_stored; // RL16
    end

    // Write-one clears, summary positions are not stored
    assign irq_clr = wr_top ? reg_wdata : 8'h00; // RL17

    pgfti_sticky_bank #(
        .WIDTH(8)
    ) u_irq_bank (
        .mclk(mclk),
        .rstn(rstn),
        .flush(soft_reset_pulse),
        .set_vec(irq_set),
        .clr_vec(irq_clr),
        .flag(top_irq)
    );

    // Live summaries of the per-regulator interrupt registers
    assign linear_summary_irq = |linear_irq_register; // RL9
    assign stepdown_summary_irq = |stepdown_irq_register; // RL10

    // Interrupt output from all unmasked pending bits
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |({top_irq[7], linear_summary_irq, stepdown_summary_irq, top_irq[4:0]}
                & ~top_irq_mask); // RL19
        end
    end

    // ------------------------------------------------------------
    // Regulator and general output protection
    // ------------------------------------------------------------
    assign protect_event = irq_set[PGFTI_POS_THERM_SD_IRQ] || irq_set[PGFTI_POS_OVERVOLT_IRQ];

    // Request history for rising-edge enabling
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            en_req_q <= 4'h0;
            gen_out_a_req_q <= 1'b0;
            gen_out_b_req_q <= 1'b0;
        end else begin
            en_req_q <= regulator_en_req;
            gen_out_a_req_q <= general_output_a_req;
            gen_out_b_req_q <= general_output_b_req;
        end
    end

    // Regulator enables: dropped on protection, blocked while shutdown flag stays set
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            regulator_en <= 4'h0;
        end else if (protect_event || soft_reset_pulse) begin
            regulator_en <= 4'h0; // RL12 RL15
        end else if (top_irq[PGFTI_POS_THERM_SD_IRQ]) begin
            regulator_en <= 4'h0; // RL13
        end else begin
            regulator_en <= regulator_en_req & (regulator_en | ~en_req_q); // Fresh request edge re-arms
        end
    end

    // General outputs: driven low on protection until the request is raised again
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            general_output_a <= 1'b0;
            general_output_b <= 1'b0;
        end else if (protect_event || soft_reset_pulse) begin
            general_output_a <= 1'b0; // RL12 RL15
            general_output_b <= 1'b0; // RL12 RL15
        end else begin
            general_output_a <= general_output_a_req && (general_output_a || !gen_out_a_req_q);
            general_output_b <= general_output_b_req && (general_output_b || !gen_out_b_req_q);
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    // Read data mux, unmapped and reserved bits read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            PGFTI_ADDR_PG_CTRL_ONE: next_rdata = pg_ctrl_one;
            PGFTI_ADDR_PG_CTRL_TWO: next_rdata = {5'h00, pg_ctrl_two};
            PGFTI_ADDR_FAULT_LATCH: next_rdata = {4'h0, fault_latch};
            PGFTI_ADDR_SOFT_RESET: next_rdata = 8'h00; // RL7
            PGFTI_ADDR_TOP_IRQ: next_rdata = {top_irq[7], linear_summary_irq, // RL9
                stepdown_summary_irq, top_irq[4:0]}; // RL10
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data captured on the read strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // pgfti_top

`default_nettype wire

// File: tb/pgfti_top_chk.sv
// Port checker for the power-good and top interrupt block
`timescale 1ns/1ps
`default_nettype none
module pgfti_top_chk (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic thermal_shutdown,
    input wire logic input_overvolt,
    input wire logic sync_clk_present,
    input wire logic [7:0] linear_irq_register,
    input wire logic [7:0] top_irq_mask,
    input wire logic [3:0] regulator_en,
    input wire logic general_output_a,
    input wire logic general_output_b,
    input wire logic power_good_out,
    input wire logic irq_out,
    input wire logic otp_reload,
    input wire logic serial_if_reset
);
    // ------------------------------
    // Assertions
    // ------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_soft_reset_pulse: assert property (
        reg_wr && reg_addr == 8'h18 && reg_wdata[0] |-> ##[1:2] (otp_reload && serial_if_reset))
        else $error("soft reset pulse missing");
    a_reset_self_clear: assert property (
        otp_reload |=> !otp_reload) else $error("soft reset pulse too long");
    a_shutdown_cuts_outputs: assert property (
        $rose(thermal_shutdown) |-> ##[1:2] (regulator_en == 4'h0 && !general_output_a && !general_output_b))
        else $error("outputs kept on thermal shutdown");
    a_overvolt_cuts_outputs: assert property (
        $rose(input_overvolt) |-> ##[1:2] (regulator_en == 4'h0 && !general_output_a && !general_output_b))
        else $error("outputs kept on overvoltage");
    a_mask_all_quiet: assert property (
        (top_irq_mask == 8'hFF) [*2] |-> !irq_out) else $error("interrupt while fully masked");
    a_linear_summary_irq: assert property (
        (linear_irq_register != 8'h00 && !top_irq_mask[6]) [*3] |-> irq_out)
        else $error("linear summary not raised");
    a_pg_drop_irq: assert property (
        $fell(power_good_out) && top_irq_mask == 8'h00 |-> ##[1:3] irq_out) else $error("power-good drop missed");
    a_sync_change_irq: assert property (
        $changed(sync_clk_present) && top_irq_mask == 8'h00 |-> ##[1:3] irq_out) else $error("sync change missed");
endmodule // pgfti_top_chk

bind pgfti_top pgfti_top_chk i_pgfti_top_chk (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .thermal_shutdown(thermal_shutdown), .input_overvolt(input_overvolt),
    .sync_clk_present(sync_clk_present), .linear_irq_register(linear_irq_register), .top_irq_mask(top_irq_mask),
    .regulator_en(regulator_en), .general_output_a(general_output_a), .general_output_b(general_output_b),
    .power_good_out(power_good_out), .irq_out(irq_out), .otp_reload(otp_reload), .serial_if_reset(serial_if_reset));
`default_nettype wire

// File: tb/pgfti_host_model.sv
// Host register master on the decoded byte port
`timescale 1ns/1ps
`default_nettype none
module pgfti_host_model (
    input wire logic mclk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One write; acknowledges and latch clears are sent as ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // One read strobe, data is picked up by the bench monitor
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule // pgfti_host_model
`default_nettype wire

// File: tb/pgfti_tb_top.sv
// Self-checking bench for the power-good and top interrupt block
`timescale 1ns/1ps
`default_nettype none
module pgfti_tb_top;
    import pgfti_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr, reg_rd, general_output_a, general_output_b, power_good_out, irq_out, otp_reload, serial_if_reset;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] regulator_valid = 4'hF, regulator_en_req = 4'h0, regulator_en;
    logic thermal_warn = 1'b0, thermal_shutdown = 1'b0, input_overvolt = 1'b0;
    logic sync_clk_present = 1'b0, current_result_stored = 1'b0, ga_req = 1'b0, gb_req = 1'b0;
    logic [7:0] stepdown_irq_register = 8'h00, linear_irq_register = 8'h00, top_irq_mask = 8'h00;
    logic [7:0] exp_q[$];
    logic [7:0] ev_bit [5] = '{8'h10, 8'h10, 8'h01, 8'h02, 8'h08};
    logic rd_d = 1'b0;
    logic [31:0] seed = 32'h257C;
    int error_cnt = 0, compares = 0, cyc_cnt = 0, pulse_cnt = 0;

    // Clock
    always #4 mclk = ~mclk;

    pgfti_host_model i_pgfti_host_model (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    pgfti_top i_pgfti_top (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .regulator_valid(regulator_valid), .thermal_warn(thermal_warn),
        .thermal_shutdown(thermal_shutdown), .input_overvolt(input_overvolt), .sync_clk_present(sync_clk_present),
        .current_result_stored(current_result_stored), .stepdown_irq_register(stepdown_irq_register),
        .linear_irq_register(linear_irq_register), .top_irq_mask(top_irq_mask), .regulator_en_req(regulator_en_req),
        .general_output_a_req(ga_req), .general_output_b_req(gb_req), .regulator_en(regulator_en),
        .general_output_a(general_output_a), .general_output_b(general_output_b), .power_good_out(power_good_out),
        .irq_out(irq_out), .otp_reload(otp_reload), .serial_if_reset(serial_if_reset));

    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_pgfti_host_model.wr(a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_pgfti_host_model.rd(a);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Read-data monitor, soft reset pulse counter and timeout
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        cyc_cnt++;
        if (otp_reload === 1'b1 && serial_if_reset === 1'b1) pulse_cnt++;
        if (rd_d && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
        if (cyc_cnt == 3000) begin
            error_cnt++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        cyc(8);
        rstn <= 1'b1;
        wr(8'h3C, 8'hFF);
        rd_chk(8'h3C, 8'h00);
        rd_chk(8'h15, PGFTI_RST_PG_CTRL_ONE);
        rd_chk(8'h16, {5'h00, PGFTI_RST_PG_CTRL_TWO});
        rd_chk(8'h17, {4'h0, PGFTI_RST_FAULT_LATCH});
        rd_chk(8'h18, 8'h00);
        rd_chk(8'h19, PGFTI_RST_TOP_IRQ);
        $display("test defaults done");
        check({7'h00, power_good_out}, 8'h00);
        wr(8'h16, 8'h05);
        cyc(3);
        check({7'h00, power_good_out}, 8'h01);
        regulator_valid <= 4'hB;
        cyc(3);
        check({7'h00, power_good_out}, 8'h00);
        check({7'h00, irq_out}, 8'h01);
        rd_chk(8'h17, 8'h04);
        rd_chk(8'h19, 8'h80);
        wr(8'h15, 8'h7B);
        cyc(3);
        check({7'h00, power_good_out}, 8'h01);
        wr(8'h17, 8'h04);
        rd_chk(8'h17, 8'h04);
        regulator_valid <= 4'hF;
        wr(8'h17, 8'h04);
        rd_chk(8'h17, 8'h00);
        wr(8'h19, 8'h00);
        rd_chk(8'h19, 8'h80);
        wr(8'h15, 8'hFF);
        cyc(3);
        check({7'h00, power_good_out}, 8'h00);
        wr(8'h15, 8'h7F);
        wr(8'h19, 8'h80);
        rd_chk(8'h19, 8'h00);
        wr(8'h16, 8'h07);
        regulator_valid <= 4'hE;
        cyc(2);
        regulator_valid <= 4'hF;
        cyc(3);
        check({7'h00, power_good_out}, 8'h00);
        rd_chk(8'h17, 8'h01);
        wr(8'h17, 8'h01);
        cyc(3);
        check({7'h00, power_good_out}, 8'h01);
        thermal_warn <= 1'b1;
        cyc(3);
        check({7'h00, power_good_out}, 8'h00);
        rd_chk(8'h19, 8'h84);
        wr(8'h16, 8'h03);
        cyc(3);
        check({7'h00, power_good_out}, 8'h01);
        thermal_warn <= 1'b0;
        wr(8'h19, 8'h84);
        $display("test power good done");
        for (int k = 0; k < 5; k++) begin
            regulator_en_req <= 4'h0;
            ga_req <= 1'b0;
            gb_req <= 1'b0;
            cyc(2);
            regulator_en_req <= 4'hF;
            ga_req <= 1'b1;
            gb_req <= 1'b1;
            cyc(3);
            case (k)
                0: sync_clk_present <= 1'b1;
                1: sync_clk_present <= 1'b0;
                2: current_result_stored <= 1'b1;
                3: input_overvolt <= 1'b1;
                default: thermal_shutdown <= 1'b1;
            endcase
            cyc(1);
            current_result_stored <= 1'b0;
            cyc(3);
            rd_chk(8'h19, ev_bit[k]);
            check({7'h00, irq_out}, 8'h01);
            if (k > 2) check({regulator_en, 2'b00, general_output_a, general_output_b}, 8'h00);
            regulator_en_req <= 4'h0;
            cyc(2);
            regulator_en_req <= 4'hF;
            cyc(3);
            if (k == 4) check({4'h0, regulator_en}, 8'h00);
            wr(8'h19, 8'h00);
            rd_chk(8'h19, ev_bit[k]);
            wr(8'h19, ev_bit[k]);
            rd_chk(8'h19, 8'h00);
            cyc(2);
            check({7'h00, irq_out}, 8'h00);
        end
        thermal_shutdown <= 1'b0;
        regulator_en_req <= 4'h0;
        cyc(2);
        regulator_en_req <= 4'hF;
        cyc(3);
        check({4'h0, regulator_en}, 8'h0F);
        $display("test events done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            linear_irq_register <= (i == 3) ? 8'h00 : seed[7:0];
            stepdown_irq_register <= (i == 2) ? 8'h00 : seed[15:8];
            cyc(3);
            wr(8'h19, 8'h60);
            rd_chk(8'h19, {1'b0, linear_irq_register != 8'h00, stepdown_irq_register != 8'h00, 5'h00});
        end
        $display("test summaries done");
        top_irq_mask <= 8'hFF;
        wr(8'h16, 8'h00);
        wr(8'h18, 8'h01);
        cyc(4);
        check(pulse_cnt[7:0], 8'h01);
        rd_chk(8'h16, {5'h00, PGFTI_RST_PG_CTRL_TWO});
        rd_chk(8'h18, 8'h00);
        cyc(3);
        $display("test soft reset done");
        conclude();
    end
endmodule // pgfti_tb_top
`default_nettype wire
